/* File: bidio_top.sv */
// Five bidirectional ports with buzzer pair, interrupt pin and oscillator-shared lines.
// Assumes CPU reaches registers by data-memory address with one-cycle strobes;
// pad inputs are synchronous to clk_sys_i. Bit ops are done by the CPU as
// read-modify-write, so the block needs no special bit-write path.
module bidio_top #(
  parameter logic [7:0] WAKE_EN_A = 8'hFF,
  parameter logic SCHMITT_A = 1'b1,
  parameter logic [4:0] PULLUP_EN = 5'h1F,
  parameter logic BUZZER_EN = 1'b0,
  parameter logic OSC_RC_IO = 1'b1
) (
  // System
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // CPU data memory access
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic hit_o,
  // Timer 0 overflow pulse
  input wire logic tmr0_ovf_i,
  // Halt state from CPU
  input wire logic halt_i,
  // Pads
  input wire logic [7:0] port_a_i,
  input wire logic [7:0] port_b_i,
  input wire logic [7:0] port_c_i,
  input wire logic [7:0] port_d_i,
  input wire logic [7:0] port_g_i,
  output logic [7:0] port_a_o,
  output logic [7:0] port_b_o,
  output logic [7:0] port_c_o,
  output logic [7:0] port_d_o,
  output logic [7:0] port_g_o,
  output logic [7:0] port_a_oe_o,
  output logic [7:0] port_b_oe_o,
  output logic [7:0] port_c_oe_o,
  output logic [7:0] port_d_oe_o,
  output logic [7:0] port_g_oe_o,
  // Pull-high enables per line
  output logic [7:0] port_a_pu_o,
  output logic [7:0] port_b_pu_o,
  output logic [7:0] port_c_pu_o,
  output logic [7:0] port_d_pu_o,
  output logic [7:0] port_g_pu_o,
  // Build option seen by pad cells; wake and interrupt to system
  output logic port_a_schmitt_o,
  output logic wake_o,
  output logic ext_irq_o
);
  logic [7:0] data_reg [bidio_pkg::NUM_PORTS];
  logic [7:0] dir_reg [bidio_pkg::NUM_PORTS];
  logic [7:0] pad_in [bidio_pkg::NUM_PORTS];
  logic [7:0] rd_val [bidio_pkg::NUM_PORTS];
  logic [7:0] pad_out [bidio_pkg::NUM_PORTS];
  logic [7:0] pad_oe [bidio_pkg::NUM_PORTS];
  logic [7:0] impl_mask [bidio_pkg::NUM_PORTS];
  logic [7:0] pa_prev_reg;
  logic pa_primed_reg;
  logic [7:0] rdata_reg;
  logic div_sig;
  logic [7:0] b_alt_en;
  logic [7:0] b_alt_val;
  logic [4:0] sel_data;
  logic [4:0] sel_dir;
  logic [7:0] g_mask;

  // Port G bits 1 and 2 exist only in internal RC plus I/O mode
  assign g_mask = OSC_RC_IO ? bidio_pkg::PORT_G_MASK
                            : (bidio_pkg::PORT_G_MASK & 8'hF9);

  always_comb begin
    impl_mask[0] = 8'hFF;
    impl_mask[1] = 8'hFF;
    impl_mask[2] = 8'hFF;
    impl_mask[3] = 8'hFF;
    impl_mask[4] = g_mask;
  end

  // Address decode
  always_comb begin
    sel_data = 5'h00;
    sel_dir = 5'h00;
    unique case (addr_i)
      bidio_pkg::ADDR_PORT_A: sel_data[0] = 1'b1;
      bidio_pkg::ADDR_PORT_B: sel_data[1] = 1'b1;
      bidio_pkg::ADDR_PORT_C: sel_data[2] = 1'b1;
      bidio_pkg::ADDR_PORT_D: sel_data[3] = 1'b1;
      bidio_pkg::ADDR_PORT_G: sel_data[4] = 1'b1;
      bidio_pkg::ADDR_PORT_A_DIR: sel_dir[0] = 1'b1;
      bidio_pkg::ADDR_PORT_B_DIR: sel_dir[1] = 1'b1;
      bidio_pkg::ADDR_PORT_C_DIR: sel_dir[2] = 1'b1;
      bidio_pkg::ADDR_PORT_D_DIR: sel_dir[3] = 1'b1;
      bidio_pkg::ADDR_PORT_G_DIR: sel_dir[4] = 1'b1;
      default: begin
        sel_data = 5'h00;
        sel_dir = 5'h00;
      end
    endcase
  end

  assign hit_o = |{sel_data, sel_dir};

  // Latches hold until rewritten; all lines inputs after reset
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < bidio_pkg::NUM_PORTS; i++) begin
        data_reg[i] <= bidio_pkg::DATA_RESET;
      end
    end else if (wr_i) begin
      for (int i = 0; i < bidio_pkg::NUM_PORTS; i++) begin
        if (sel_data[i]) begin
          data_reg[i] <= wdata_i & impl_mask[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < bidio_pkg::NUM_PORTS; i++) begin
        dir_reg[i] <= bidio_pkg::DIR_RESET;
      end
    end else if (wr_i) begin
      for (int i = 0; i < bidio_pkg::NUM_PORTS; i++) begin
        if (sel_dir[i]) begin
          // Unimplemented bits stay input so they never drive
          dir_reg[i] <= wdata_i | ~impl_mask[i];
        end
      end
    end
  end

  // Read data: pad sampled at the read strobe, no input latch
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_i) begin
      rdata_reg <= 8'h00;
      for (int i = 0; i < bidio_pkg::NUM_PORTS; i++) begin
        if (sel_data[i]) begin
          // Disabled oscillator-shared lines read 0, not their pads
          rdata_reg <= rd_val[i] & impl_mask[i];
        end
        if (sel_dir[i]) begin
          rdata_reg <= dir_reg[i] & impl_mask[i];
        end
      end
    end
  end
  assign rdata_o = rdata_reg;

  bidio_buzzer_div u_div (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ovf_i(tmr0_ovf_i),
    .div_o(div_sig)
  );

  // Buzzer mux on port B lines 0 and 1
  always_comb begin
    b_alt_en = 8'h00;
    b_alt_val = 8'h00;
    if (BUZZER_EN && !dir_reg[1][bidio_pkg::BUZ_LINE_0_BIT]) begin
      // Line 0 data gates both outputs; line 1 data unused
      b_alt_en[bidio_pkg::BUZ_LINE_0_BIT] = 1'b1;
      b_alt_val[bidio_pkg::BUZ_LINE_0_BIT] = data_reg[1][bidio_pkg::BUZ_LINE_0_BIT] & div_sig;
      b_alt_en[bidio_pkg::BUZ_LINE_1_BIT] = 1'b1;
      b_alt_val[bidio_pkg::BUZ_LINE_1_BIT] = data_reg[1][bidio_pkg::BUZ_LINE_0_BIT] & ~div_sig;
    end
  end

  always_comb begin
    pad_in[0] = port_a_i;
    pad_in[1] = port_b_i;
    pad_in[2] = port_c_i;
    pad_in[3] = port_d_i;
    pad_in[4] = port_g_i;
  end

  for (genvar g = 0; g < bidio_pkg::NUM_PORTS; g++) begin : gen_port
    bidio_port_if pif ();
    assign pif.data = data_reg[g];
    assign pif.dir = dir_reg[g];
    assign pif.alt_en = (g == 1) ? b_alt_en : 8'h00;
    assign pif.alt_val = (g == 1) ? b_alt_val : 8'h00;
    assign pif.pad_in = pad_in[g];
    assign pad_out[g] = pif.pad_out;
    assign pad_oe[g] = pif.pad_oe;
    assign rd_val[g] = pif.rd_val;
    bidio_port_slice #(
      .IMPL_MASK((g == 4) ? bidio_pkg::PORT_G_MASK : 8'hFF)
    ) u_slice (
      .p(pif.slice)
    );
  end

  assign port_a_o = pad_out[0];
  assign port_b_o = pad_out[1];
  assign port_c_o = pad_out[2];
  assign port_d_o = pad_out[3];
  assign port_g_o = pad_out[4] & g_mask;
  assign port_a_oe_o = pad_oe[0];
  assign port_b_oe_o = pad_oe[1];
  assign port_c_oe_o = pad_oe[2];
  assign port_d_oe_o = pad_oe[3];
  assign port_g_oe_o = pad_oe[4] & g_mask;

  // Pull-high only on input lines of ports whose option is set
  assign port_a_pu_o = {8{PULLUP_EN[0]}} & dir_reg[0];
  assign port_b_pu_o = {8{PULLUP_EN[1]}} & dir_reg[1];
  assign port_c_pu_o = {8{PULLUP_EN[2]}} & dir_reg[2];
  assign port_d_pu_o = {8{PULLUP_EN[3]}} & dir_reg[3];
  assign port_g_pu_o = {8{PULLUP_EN[4]}} & dir_reg[4] & g_mask;

  assign port_a_schmitt_o = SCHMITT_A;

  // External interrupt sees the pad whatever the direction
  assign ext_irq_o = port_g_i[bidio_pkg::PORT_G_IRQ_BIT];

  // Wake on any change of an enabled port A input line during halt
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pa_prev_reg <= 8'h00;
    end else begin
      pa_prev_reg <= port_a_i;
    end
  end
  // Reset value of the previous sample is not the pad level; compare only after a real sample
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pa_primed_reg <= 1'b0;
    end else begin
      pa_primed_reg <= 1'b1;
    end
  end
  assign wake_o = halt_i & pa_primed_reg & |((pa_prev_reg ^ port_a_i) & WAKE_EN_A & dir_reg[0]);
endmodule

/* File: bidio_pkg.sv */
// Constants shared by the bidirectional port block.
// Assumes a CPU data-memory style access: 8-bit address, read/write strobes.
// How it works
// - Port data latches sit at 12H, 14H, 16H, 18H and 1EH.
// - Input reads return the live pad level, sampled during the read, never latched.
// - Written output values stay in the latch until the next write.
// - Each port has a direction register at 13H, 15H, 17H, 19H, 1FH.
// - Direction 1 makes an input; 0 makes a push-pull output.
// - Reads give pad for input lines and latch for output lines.
// - After reset every line stops driving.
// - Bit set, clear and complement are read-modify-write of the whole port.
// - Every port A line set as input can wake from halt, enabled per bit at build time.
// - Upper five bits of port G read zero and ignore writes.
// - Pull-high present only when the port's build option selects it.
// - Buzzer option drives divider signal and complement on buzzer lines in output mode.
// - Buzzer option leaves input behaviour of those lines unchanged.
// - Buzzer line 0 data gates both buzzer outputs; line 1 data ignored.
// - Line 1 drives its own latch when line 0 is not buzzer.
// - Lowest port G bit doubles as the external interrupt input.
// - Port G bits 1 and 2 are I/O only in internal RC plus I/O mode.
// - Port A input buffer is CMOS or Schmitt by build option.
// - The buzzer divider signal comes from timer 0 overflow.
package bidio_pkg;
  localparam int NUM_PORTS = 5;
  localparam logic [7:0] ADDR_PORT_A = 8'h12;
  localparam logic [7:0] ADDR_PORT_A_DIR = 8'h13;
  localparam logic [7:0] ADDR_PORT_B = 8'h14;
  localparam logic [7:0] ADDR_PORT_B_DIR = 8'h15;
  localparam logic [7:0] ADDR_PORT_C = 8'h16;
  localparam logic [7:0] ADDR_PORT_C_DIR = 8'h17;
  localparam logic [7:0] ADDR_PORT_D = 8'h18;
  localparam logic [7:0] ADDR_PORT_D_DIR = 8'h19;
  localparam logic [7:0] ADDR_PORT_G = 8'h1E;
  localparam logic [7:0] ADDR_PORT_G_DIR = 8'h1F;
  localparam logic [7:0] DATA_RESET = 8'hFF;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] PORT_G_MASK = 8'h07;
  localparam int PORT_G_IRQ_BIT = 0;
  localparam int PORT_G_OSC_IN_BIT = 1;
  localparam int PORT_G_OSC_OUT_BIT = 2;
  localparam int BUZ_LINE_0_BIT = 0;
  localparam int BUZ_LINE_1_BIT = 1;
endpackage

/* File: bidio_port_if.sv */
// Signals of one port slice: latch, direction, pad view and pin drive.
// Assumes the top module owns one instance per port.
interface bidio_port_if;
  logic [7:0] data;
  logic [7:0] dir;
  logic [7:0] alt_en;
  logic [7:0] alt_val;
  logic [7:0] pad_in;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic [7:0] rd_val;
  modport slice (
    input data, dir, alt_en, alt_val, pad_in,
    output pad_out, pad_oe, rd_val
  );
  modport owner (
    output data, dir, alt_en, alt_val, pad_in,
    input pad_out, pad_oe, rd_val
  );
endinterface

/* File: bidio_port_slice.sv */
// One 8-bit port: pin drive and read-back mux.
// Assumes latch and direction come from the owner's registers.
module bidio_port_slice #(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  bidio_port_if.slice p
);
  // Output only when direction bit is 0; alternate function replaces latch
  assign p.pad_oe = ~p.dir & IMPL_MASK;
  assign p.pad_out = ((p.alt_en & p.alt_val) | (~p.alt_en & p.data)) & IMPL_MASK;
  // Input lines read pad live, output lines read latch
  assign p.rd_val = ((p.dir & p.pad_in) | (~p.dir & p.data)) & IMPL_MASK;
endmodule

/* File: bidio_buzzer_div.sv */
// Buzzer divider: square wave from timer 0 overflow pulses.
// Assumes ovf_i is a one-cycle pulse in the system clock domain.
module bidio_buzzer_div (
  // System
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Timer
  input wire logic ovf_i,
  // Divider out
  output logic div_o
);
  logic div_reg;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_reg <= 1'b0;
    end else if (ovf_i) begin
      div_reg <= ~div_reg;
    end
  end
  assign div_o = div_reg;
endmodule

/* File: bidio_chk.sv */
// Port behaviour checker for bidio_top.
// Assumes one clock domain; bound to every instance below.
module bidio_chk #(
  parameter logic [7:0] WAKE_EN_A = 8'hFF,
  parameter logic [4:0] PULLUP_EN = 5'h1F,
  parameter logic BUZZER_EN = 1'b0
) (
  // System
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // CPU side
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic hit_o,
  input wire logic tmr0_ovf_i,
  input wire logic halt_i,
  // Pads
  input wire logic [7:0] port_a_i,
  input wire logic [7:0] port_g_i,
  input wire logic [7:0] port_a_o,
  input wire logic [7:0] port_b_o,
  input wire logic [7:0] port_a_oe_o,
  input wire logic [7:0] port_b_oe_o,
  input wire logic [7:0] port_g_oe_o,
  input wire logic [7:0] port_a_pu_o,
  input wire logic wake_o,
  input wire logic ext_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  rst_idle_a: assert property ($fell(sys_rst_i) |-> port_a_oe_o == 8'h00 && port_g_oe_o == 8'h00)
    else $error("line driven after reset");
  dir_write_a: assert property (wr_i && addr_i == 8'h13 |=> port_a_oe_o == ~$past(wdata_i))
    else $error("direction write not applied");
  data_write_a: assert property (wr_i && addr_i == 8'h12 |=> ((port_a_o ^ $past(wdata_i)) & port_a_oe_o) == 8'h00)
    else $error("latch write not driven");
  latch_hold_a: assert property (!(wr_i && addr_i inside {8'h12, 8'h13}) |=> $stable(port_a_o & port_a_oe_o))
    else $error("output changed without write");
  read_mux_a: assert property (rd_i && addr_i == 8'h12 |=>
    rdata_o == ($past(port_a_i) & ~$past(port_a_oe_o) | $past(port_a_o) & $past(port_a_oe_o)))
    else $error("port read value wrong");
  g_upper_a: assert property (rd_i && addr_i[7:1] == 7'h0F |=> rdata_o[7:3] == 5'h00)
    else $error("unimplemented bits read nonzero");
  unmapped_read_a: assert property (rd_i && !hit_o |=> rdata_o == 8'h00)
    else $error("unmapped read nonzero");
  irq_pin_a: assert property (ext_irq_o == port_g_i[0])
    else $error("interrupt input not the pad");
  pull_high_a: assert property (port_a_pu_o == (PULLUP_EN[0] ? ~port_a_oe_o : 8'h00))
    else $error("pull-high wrong");
  buzz_toggle_a: assert property (BUZZER_EN && tmr0_ovf_i && !wr_i && port_b_oe_o[1:0] == 2'b11 &&
    port_b_o[1:0] == 2'b01 |=> port_b_o[1:0] == 2'b10)
    else $error("buzzer pair did not toggle");
  wake_a: assert property (halt_i && port_a_oe_o == 8'h00 && !$past(sys_rst_i) &&
    ((port_a_i ^ $past(port_a_i)) & WAKE_EN_A) != 8'h00 |-> wake_o)
    else $error("no wake on input change");
endmodule

bind bidio_top bidio_chk #(.WAKE_EN_A(WAKE_EN_A), .PULLUP_EN(PULLUP_EN), .BUZZER_EN(BUZZER_EN)) chk (.*);

/* File: bidio_pad_model.sv */
// Pads and switches of one port.
// Assumes the bench sets switch levels off the clock edge.
module bidio_pad_model (
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven lines show own level, the rest the switch
  assign pad_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule

/* File: bidio_top_test.sv */
// Self-checking bench for bidio_top with the buzzer option on.
// Assumes the pad model and checker files are compiled first.
module bidio_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ADR [5] = '{8'h12, 8'h14, 8'h16, 8'h18, 8'h1E};
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic tmr0_ovf_i = 1'b0;
  logic halt_i = 1'b0;
  logic [7:0] rdata_o;
  logic wake_o;
  logic hit_o;
  logic schmitt;
  logic [7:0] pin [5];
  logic [7:0] po [5];
  logic [7:0] poe [5];
  logic [7:0] ppu [5];
  logic [7:0] ext [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'he86ffb30;
  always #12.5 clk_sys_i = ~clk_sys_i;
  bidio_top #(.BUZZER_EN(1'b1), .SCHMITT_A(1'b1)) DUT (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o), .tmr0_ovf_i(tmr0_ovf_i), .halt_i(halt_i),
    .port_a_i(pin[0]), .port_b_i(pin[1]), .port_c_i(pin[2]), .port_d_i(pin[3]), .port_g_i(pin[4]),
    .port_a_o(po[0]), .port_b_o(po[1]), .port_c_o(po[2]), .port_d_o(po[3]), .port_g_o(po[4]),
    .port_a_oe_o(poe[0]), .port_b_oe_o(poe[1]), .port_c_oe_o(poe[2]), .port_d_oe_o(poe[3]),
    .port_g_oe_o(poe[4]), .port_a_pu_o(ppu[0]), .port_b_pu_o(ppu[1]), .port_c_pu_o(ppu[2]),
    .port_d_pu_o(ppu[3]), .port_g_pu_o(ppu[4]), .port_a_schmitt_o(schmitt), .wake_o(wake_o), .ext_irq_o());
  for (genvar k = 0; k < 5; k++) begin : g_pad
    bidio_pad_model pad (.out_i(po[k]), .oe_i(poe[k]), .ext_i(ext[k]), .pad_o(pin[k]));
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One strobe cycle; read data is settled by the next falling edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    wr_i = w;
    rd_i = !w;
    addr_i = a;
    wdata_i = d;
    @(negedge clk_sys_i);
    wr_i = 1'b0;
    rd_i = 1'b0;
  endtask
  function automatic logic [7:0] rd_exp(input logic [7:0] d, r, p, m);
    return ((d & ~r) | (p & r)) & m;
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    logic [7:0] d, r, m;
    repeat (10) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    for (int k = 0; k < 5; k++) check(poe[k], 8'h00);
    check({7'h00, schmitt}, 8'h01);
    repeat (20) begin
      for (int k = 0; k < 5; k++) begin
        d = 8'($random(seed));
        r = 8'($random(seed));
        m = (k == 4) ? bidio_pkg::PORT_G_MASK : 8'hFF;
        ext[k] = 8'($random(seed));
        acc(1'b1, ADR[k] + 8'h01, r);
        acc(1'b1, ADR[k], d);
        acc(1'b0, ADR[k], 8'h00);
        check(rdata_o, rd_exp(d, r, ext[k], m));
        acc(1'b0, ADR[k] + 8'h01, 8'h00);
        check(rdata_o, r & m);
        check({7'h00, hit_o}, 8'h01);
        check(poe[k], ~r & m);
        if (k != 1) check(po[k] & poe[k], d & ~r & m);
        check(ppu[k], r & m);
      end
    end
    acc(1'b1, 8'h20, 8'hA5);
    acc(1'b0, 8'h20, 8'h00);
    check(rdata_o, 8'h00);
    check({7'h00, hit_o}, 8'h00);
    $display("random port test done");
    acc(1'b1, 8'h15, 8'h00);
    acc(1'b1, 8'h14, 8'h01);
    for (int i = 0; i < 4; i++) begin
      check(po[1] & 8'h03, i[0] ? 8'h01 : 8'h02);
      @(negedge clk_sys_i);
      tmr0_ovf_i = 1'b1;
      @(negedge clk_sys_i);
      tmr0_ovf_i = 1'b0;
    end
    acc(1'b1, 8'h14, 8'h02);
    check(po[1] & 8'h03, 8'h00);
    acc(1'b1, 8'h15, 8'h03);
    ext[1] = 8'h01;
    acc(1'b0, 8'h14, 8'h00);
    check(rdata_o, 8'h01);
    $display("buzzer test done");
    acc(1'b1, 8'h13, 8'hFF);
    halt_i = 1'b1;
    ext[0] = ~ext[0];
    #1;
    check({7'h00, wake_o}, 8'h01);
    @(negedge clk_sys_i);
    check({7'h00, wake_o}, 8'h00);
    halt_i = 1'b0;
    $display("wake test done");
    // Software parks every line as an output before leaving
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, ADR[k] + 8'h01, 8'h00);
      check(poe[k], (k == 4) ? bidio_pkg::PORT_G_MASK : 8'hFF);
    end
    $display("unused line test done");
    end_of_test();
  end
endmodule
